// file: hw/vsc_consts.svh
// timing counts, widths and array layout for the voice store control block
`ifndef VSC_CONSTS_SVH
`define VSC_CONSTS_SVH
`define VSC_ADDR_W 10
`define VSC_LAST_ADDR 10'h3FF
`define VSC_FIRST_ADDR 10'h000
`define VSC_CLK_PERIOD_NS 10
`define VSC_EOM_TIME_NS 12500
`define VSC_EOM_CYCLES ((`VSC_EOM_TIME_NS + `VSC_CLK_PERIOD_NS - 1) / `VSC_CLK_PERIOD_NS)
`define VSC_OVF_TIME_NS 12500
`define VSC_OVF_CYCLES ((`VSC_OVF_TIME_NS + `VSC_CLK_PERIOD_NS - 1) / `VSC_CLK_PERIOD_NS)
`define VSC_CNT_W 16
`endif

// file: hw/vsc_latch.sv
// falling-edge capture of address and play select
`timescale 1ns/1ns
`include "vsc_consts.svh"
module vsc_latch (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic enable_n_i,
  input wire vsc_pkg::vsc_latch_t pins_i,
  output logic fall_o,
  output vsc_pkg::vsc_latch_t held_o
);
  import vsc_pkg::*;
  logic enable_n_q;
  vsc_latch_t held_q;
  vsc_latch_t held_d;

  assign fall_o = enable_n_q && !enable_n_i;

  always_comb begin
    held_d = held_q;
    if (fall_o) begin
      held_d = pins_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      enable_n_q <= 1'b1;
      held_q <= '0;
    end else if (en_i) begin
      enable_n_q <= enable_n_i;
      held_q <= held_d;
    end
  end

  assign held_o = held_q;
endmodule

// file: hw/vsc_pkg.sv
// types shared by the voice store control block
package vsc_pkg;
  typedef enum logic [1:0] {
    VSC_IDLE = 2'b00,
    VSC_REC = 2'b01,
    VSC_PLAY = 2'b10,
    VSC_HOLD = 2'b11
  } vsc_state_t;

  // one array location access toward the storage core
  typedef struct packed {
    logic [9:0] addr;
    logic write;
    logic mark;
  } vsc_access_t;

  typedef struct packed {
    logic [9:0] addr;
    logic play;
  } vsc_latch_t;
endpackage

// file: hw/vsc_pulse.sv
// fixed-length active pulse timer
`timescale 1ns/1ns
`include "vsc_consts.svh"
module vsc_pulse #(
  parameter logic [15:0] CYCLES = 16'h0001
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic start_i,
  output logic active_o
);
  import vsc_pkg::*;
  logic [`VSC_CNT_W-1:0] cnt_q;
  logic [`VSC_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = CYCLES;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (en_i) begin
      cnt_q <= cnt_d;
    end
  end

  assign active_o = (cnt_q != '0);
endmodule

// file: hw/vsc_top.sv
// control and status pin logic of the voice store device
`timescale 1ns/1ns
`include "vsc_consts.svh"
module vsc_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic enable_n_i,
  input wire logic standby_request_i,
  input wire logic play_not_record_i,
  input wire logic [9:0] addr_i,
  input wire logic push_button_mode_i,
  input wire logic supply_low_i,
  input wire logic external_sample_clock_i,
  input wire logic external_clock_driven_i,
  input wire logic sample_tick_i,
  input wire logic marker_found_i,
  output vsc_pkg::vsc_access_t access_o,
  output logic access_valid_o,
  output logic memory_full_strobe_n_o,
  output logic message_end_flag_o,
  output logic standby_o,
  output logic use_internal_osc_o,
  output logic sample_clock_o
);
  import vsc_pkg::*;

  vsc_state_t state_q;
  vsc_state_t state_d;
  logic [9:0] ptr_q;
  logic [9:0] ptr_d;
  logic overflowed_q;
  logic overflowed_d;
  logic start_q;
  logic start_d;
  vsc_access_t acc_q;
  vsc_access_t acc_d;
  logic acc_valid_q;
  logic acc_valid_d;
  logic eom_out_q;
  logic eom_out_d;
  logic ovf_out_q;
  logic ovf_out_d;
  logic fall;
  vsc_latch_t pins;
  vsc_latch_t held;
  logic ovf_start;
  logic ovf_active;
  logic eom_start;
  logic eom_active;
  logic busy;
  logic stop_req;
  logic step_now;
  logic clock_pin;

  function automatic logic at_last(input logic [9:0] a);
    at_last = (a == `VSC_LAST_ADDR);
  endfunction

  function automatic logic [9:0] next_addr(input logic [9:0] a);
    next_addr = a + 10'h001;
  endfunction

  function automatic vsc_access_t make_access(input logic [9:0] a,
    input logic wr, input logic mk);
    vsc_access_t r;
    r.addr = a;
    r.write = wr;
    r.mark = mk;
    return r;
  endfunction

  assign pins.addr = addr_i;
  assign pins.play = play_not_record_i;

  vsc_latch u_latch (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(clk_en_i),
    .enable_n_i(enable_n_i),
    .pins_i(pins),
    .fall_o(fall),
    .held_o(held)
  );

  // both timers share the clock enable, so a freeze stretches the pulses
  vsc_pulse #(.CYCLES(16'(`VSC_OVF_CYCLES))) u_ovf_pulse (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(clk_en_i),
    .start_i(ovf_start),
    .active_o(ovf_active)
  );

  vsc_pulse #(.CYCLES(16'(`VSC_EOM_CYCLES))) u_eom_pulse (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(clk_en_i),
    .start_i(eom_start),
    .active_o(eom_active)
  );

  // a cycle ends as soon as enable rises or standby is asked for
  assign stop_req = standby_request_i || enable_n_i;
  // one array step per tick while the cycle is still wanted
  assign step_now = sample_tick_i && !stop_req;

  // cycle control: start one edge after the latched fall
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    overflowed_d = overflowed_q;
    start_d = 1'b0;
    ovf_start = 1'b0;
    eom_start = 1'b0;
    case (state_q)
      VSC_IDLE: begin
        if (standby_request_i) begin
          ptr_d = `VSC_FIRST_ADDR;
          overflowed_d = 1'b0;
        end else if (start_q && !enable_n_i) begin
          ptr_d = held.addr;
          if (held.play) begin
            state_d = VSC_PLAY;
          end else if (!supply_low_i) begin
            state_d = VSC_REC;
          end
        end else if (fall && !overflowed_q) begin
          // work from the latched copy so the address pins may move
          // right after the fall without disturbing the cycle
          start_d = 1'b1;
        end
      end
      VSC_REC: begin
        if (stop_req) begin
          state_d = VSC_IDLE;
        end else if (supply_low_i) begin
          state_d = VSC_IDLE;
        end else if (sample_tick_i) begin
          if (at_last(ptr_q)) begin
            ovf_start = 1'b1;
            overflowed_d = 1'b1;
            state_d = VSC_HOLD;
          end else begin
            ptr_d = next_addr(ptr_q);
          end
        end
      end
      VSC_PLAY: begin
        if (stop_req) begin
          state_d = VSC_IDLE;
        end else if (sample_tick_i) begin
          if (marker_found_i) begin
            eom_start = 1'b1;
            state_d = VSC_IDLE;
          end else if (at_last(ptr_q)) begin
            ovf_start = 1'b1;
            overflowed_d = 1'b1;
            state_d = VSC_HOLD;
          end else begin
            ptr_d = next_addr(ptr_q);
          end
        end
      end
      // a filled array waits here; only standby rearms it
      VSC_HOLD: begin
        if (standby_request_i) begin
          ptr_d = `VSC_FIRST_ADDR;
          overflowed_d = 1'b0;
          state_d = VSC_IDLE;
        end
      end
      default: begin
        state_d = VSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q <= VSC_IDLE;
      ptr_q <= `VSC_FIRST_ADDR;
      overflowed_q <= 1'b0;
      start_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      overflowed_q <= overflowed_d;
      start_q <= start_d;
    end
  end

  // array access requests: the data step or the closing marker
  always_comb begin
    acc_d = acc_q;
    acc_valid_d = 1'b0;
    case (state_q)
      VSC_REC: begin
        if (stop_req) begin
          // closing marker lands at the current address
          acc_d = make_access(ptr_q, 1'b1, 1'b1);
          acc_valid_d = 1'b1;
        end else if (step_now && !supply_low_i) begin
          acc_d = make_access(ptr_q, 1'b1, 1'b0);
          acc_valid_d = 1'b1;
        end
      end
      VSC_PLAY: begin
        if (step_now) begin
          acc_d = make_access(ptr_q, 1'b0, 1'b0);
          acc_valid_d = 1'b1;
        end
      end
      default: begin
        acc_valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      acc_q <= '0;
      acc_valid_q <= 1'b0;
    end else if (clk_en_i) begin
      acc_q <= acc_d;
      acc_valid_q <= acc_valid_d;
    end
  end

  // busy drives the activity output and holds standby off
  assign busy = (state_q == VSC_REC) || (state_q == VSC_PLAY);

  // full strobe: pulse, then a copy of enable for the next part in line
  always_comb begin
    if (ovf_active) begin
      ovf_out_d = 1'b0;
    end else if (overflowed_q) begin
      ovf_out_d = enable_n_i;
    end else begin
      ovf_out_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ovf_out_q <= 1'b1;
    end else if (clk_en_i) begin
      ovf_out_q <= ovf_out_d;
    end
  end

  // message-end pin; a supply drop outranks the marker pulse
  always_comb begin
    if (push_button_mode_i) begin
      eom_out_d = busy;
    end else if (supply_low_i) begin
      eom_out_d = 1'b0;
    end else begin
      eom_out_d = !eom_active;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      eom_out_q <= 1'b1;
    end else if (clk_en_i) begin
      eom_out_q <= eom_out_d;
    end
  end

  assign access_o = acc_q;
  assign access_valid_o = acc_valid_q;
  assign memory_full_strobe_n_o = ovf_out_q;
  assign message_end_flag_o = eom_out_q;
  // standby only when not in a cycle; a pending overflow does not hold it off
  assign standby_o = standby_request_i && !busy;
  // the pull-down makes an undriven pin read low; the source choice
  // follows whether the pin is driven, never the clock level itself
  assign clock_pin = external_clock_driven_i && external_sample_clock_i;
  assign use_internal_osc_o = !external_clock_driven_i;
  assign sample_clock_o = clock_pin;
endmodule

// file: sim/testbench.sv
// self-checking bench for the voice store control pins
`timescale 1ns/1ns
module testbench;
  import vsc_pkg::*;
  logic clk_i = 0, resetn_i = 0, clk_en_i = 1, enable_n_i = 1, run = 0;
  logic standby_request_i = 0, play_not_record_i = 0;
  logic push_button_mode_i = 0, supply_low_i = 0, marker_found_i = 0;
  logic external_sample_clock_i = 0, external_clock_driven_i = 0;
  logic [9:0] addr_i = 10'h000;
  logic sample_tick_i, access_valid_o, memory_full_strobe_n_o;
  logic message_end_flag_o, standby_o, use_internal_osc_o, sample_clock_o;
  vsc_access_t access_o;
  vsc_access_t seen[$];
  int fail_count = 0, checks_done = 0;
  initial forever #5 clk_i = ~clk_i;
  vsc_core_model i_vsc_core_model (.clk_i, .run_i(run),
    .sample_tick_o(sample_tick_i));
  vsc_top i_vsc_top (.*);
  always @(negedge clk_i) if (access_valid_o) seen.push_back(access_o);
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // inputs move after the latch edge to show they are no longer used
  task automatic go(input logic p, input logic [9:0] a);
    seen.delete();
    play_not_record_i = p;
    addr_i = a;
    enable_n_i = 0;
    run = 1;
    step(1);
    addr_i = ~a;
    play_not_record_i = ~p;
  endtask
  task automatic halt();
    enable_n_i = 1;
    run = 0;
    step(4);
  endtask
  task automatic t_rec();
    go(0, 10'h155);
    step(6);
    halt();
    chk(seen[0], {10'h155, 2'h2});
    chk(seen[1], {10'h156, 2'h3});
  endtask
  task automatic t_full();
    go(1, 10'h3FE);
    step(10);
    run = 0;
    chk(seen[1], {10'h3FF, 2'h0});
    chk(memory_full_strobe_n_o, 1'b0);
    step(1300);
    chk(memory_full_strobe_n_o, 1'b0);
    enable_n_i = 1;
    step(3);
    chk(memory_full_strobe_n_o, 1'b1);
    standby_request_i = 1;
    step(2);
    chk(standby_o, 1'b1);
    standby_request_i = 0;
    go(0, 10'h000);
    step(6);
    chk(memory_full_strobe_n_o, 1'b1);
    chk(seen[0], {10'h000, 2'h2});
    halt();
  endtask
  // a held clock enable must stall the fall detector and the cycle alike
  task automatic t_frz();
    seen.delete();
    clk_en_i = 0;
    play_not_record_i = 0;
    addr_i = 10'h040;
    enable_n_i = 0;
    run = 1;
    step(8);
    chk(12'(seen.size()), 12'h000);
    clk_en_i = 1;
    step(8);
    halt();
    chk(seen[0], {10'h040, 2'h2});
  endtask
  task automatic t_osc();
    external_sample_clock_i = 1;
    step(1);
    chk(sample_clock_o, 1'b0);
    chk(use_internal_osc_o, 1'b1);
    external_clock_driven_i = 1;
    step(1);
    chk(sample_clock_o, 1'b1);
    chk(use_internal_osc_o, 1'b0);
    external_sample_clock_i = 0;
    step(1);
    chk(sample_clock_o, 1'b0);
    chk(use_internal_osc_o, 1'b0);
  endtask
  task automatic message_end_pulse_time();
    int n;
    marker_found_i = 1;
    go(1, 10'h010);
    step(10);
    n = seen.size();
    chk(message_end_flag_o, 1'b0);
    step(1200);
    chk(message_end_flag_o, 1'b0);
    step(100);
    chk(message_end_flag_o, 1'b1);
    chk(12'(seen.size()), 12'(n));
    marker_found_i = 0;
    halt();
  endtask
  task automatic t_low();
    supply_low_i = 1;
    step(3);
    chk(message_end_flag_o, 1'b0);
    go(0, 10'h020);
    step(6);
    halt();
    chk(12'(seen.size()), 12'h000);
    supply_low_i = 0;
  endtask
  task automatic t_pbm();
    push_button_mode_i = 1;
    go(1, 10'h030);
    step(3);
    chk(message_end_flag_o, 1'b1);
    halt();
    chk(message_end_flag_o, 1'b0);
    push_button_mode_i = 0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  initial begin
    step(12);
    resetn_i = 1;
    step(2);
    t_rec();
    t_frz();
    message_end_pulse_time();
    t_low();
    t_pbm();
    t_osc();
    t_full();
    test_done();
  end
endmodule

// file: sim/vsc_core_model.sv
// storage core stand-in giving one array step tick every four cycles
`timescale 1ns/1ns
module vsc_core_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic sample_tick_o
);
  logic [1:0] cnt_q = 2'h0;
  always_ff @(posedge clk_i) cnt_q <= run_i ? cnt_q + 2'h1 : 2'h0;
  assign sample_tick_o = run_i && cnt_q == 2'h3;
endmodule

// file: sim/vsc_top_assertions.sv
// concurrent checks on the voice store control pins
`timescale 1ns/1ns
module vsc_top_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic enable_n_i,
  input wire logic standby_request_i,
  input wire logic push_button_mode_i,
  input wire logic supply_low_i,
  input wire logic external_clock_driven_i,
  input wire logic access_valid_o,
  input wire logic memory_full_strobe_n_o,
  input wire logic message_end_flag_o,
  input wire logic standby_o,
  input wire logic use_internal_osc_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_low; supply_low_i && !push_button_mode_i; endsequence
  sequence s_off; enable_n_i [*3]; endsequence
  // the end-of-record marker write lands one edge after enable rises
  property p_quiet; s_off |=> !access_valid_o; endproperty
  a_quiet: assert property (p_quiet) else $error("access when off");
  property p_sby; s_off ##0 standby_request_i |-> standby_o; endproperty
  a_sby: assert property (p_sby) else $error("no standby");
  // a fall with enable low two edges back cannot be mirroring
  property p_full;
    $fell(memory_full_strobe_n_o) && !$past(enable_n_i, 2)
      |-> !memory_full_strobe_n_o [*8];
  endproperty
  a_full: assert property (p_full) else $error("short full");
  property p_mirror;
    $rose(memory_full_strobe_n_o)
      |-> $past(enable_n_i) || $past(standby_request_i);
  endproperty
  a_mirror: assert property (p_mirror) else $error("bad rise");
  property p_eom;
    $fell(message_end_flag_o) && !push_button_mode_i && !supply_low_i
      |-> !message_end_flag_o [*8];
  endproperty
  a_eom: assert property (p_eom) else $error("short end");
  property p_low; s_low ##1 s_low |-> !message_end_flag_o; endproperty
  a_low: assert property (p_low) else $error("low not shown");
  property p_osc; !external_clock_driven_i |-> use_internal_osc_o; endproperty
  a_osc: assert property (p_osc) else $error("no internal");
  property p_ext; external_clock_driven_i |-> !use_internal_osc_o; endproperty
  a_ext: assert property (p_ext) else $error("no external");
endmodule
bind vsc_top vsc_top_chk i_vsc_top_chk (.*);
